/* File: tb_top.sv */
`timescale 1ns/1ps
`include "tdp_consts.vh"
// self-checking bench for the touch detect core
module tb_top;
  localparam TK = 10; // short tick keeps the run brief
  localparam PM = 5;
  reg clk_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg sa = 1'b1, sb = 1'b1, ga = 1'b0, gb = 1'b0;
  reg [15:0] lvl = 16'h1000; // level the front end reports
  reg [7:0] awa = 8'h00, ara = 8'h00;
  reg [31:0] wda = 32'h0;
  reg [3:0] wst = 4'hF; // write strobes
  reg awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  wire awr, wrd, bv, arr, rv, sv, bq, out_n;
  wire [1:0] br, rr;
  wire [31:0] rd;
  wire [15:0] smp;
  integer num_errors = 0;
  integer total_checks = 0;
  initial forever #2.5 clk_i = ~clk_i;
  tdp_top #(.TICK_CYCLES(TK), .BURST_MS(8), .CONFIRM_MS(3), .PULSE_MS(PM),
    .TO_SHORT_MS(40), .TO_LONG_MS(80)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .mode_strap_a_i(sa), .mode_strap_b_i(sb), .gain_on_sense_line_a_i(ga),
    .gain_on_sense_line_b_i(gb), .burst_req_o(bq), .sample_valid_i(sv), .sample_i(smp),
    .out_n_o(out_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wda), .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry));
  tdp_fe_model fe (.clk_i(clk_i), .burst_req_i(bq), .level_i(lvl),
    .sample_valid_o(sv), .sample_o(smp));
  task stop_test;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task check(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // one bus transfer; handshakes judged and released at the same rising edge
  task bus(input w, input [7:0] a, input [31:0] d, output [31:0] q, output [1:0] r);
    integer n;
    reg ta, tw, tar, tb, tr, dn;
    begin
      n = 0;
      dn = 1'b0;
      q = 32'h0;
      r = 2'h0;
      if (w) begin
        awa <= a;
        wda <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
      end else begin
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
      end
      while (!dn && n < 200) begin
        @(posedge clk_i);
        n = n + 1;
        ta = awv & awr;
        tw = wv & wrd;
        tar = arv & arr;
        tb = bry & bv;
        tr = rry & rv;
        if (tb) r = br;
        if (tr) r = rr;
        if (tr) q = rd;
        dn = tb | tr;
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
        if (tar) arv <= 1'b0;
        if (tb) bry <= 1'b0;
        if (tr) rry <= 1'b0;
      end
      // gap edge so the next call never re-drives in this step
      @(posedge clk_i);
      if (!dn) check("axi_hang", 32'h1, 32'h0);
    end
  endtask
  task rchk(input [63:0] nm, input [7:0] a, input [31:0] m, input [31:0] e);
    reg [31:0] q;
    reg [1:0] r;
    begin
      bus(1'b0, a, 32'h0, q, r);
      check(nm, e, q & m);
    end
  endtask
  // count bursts, then let register and output updates land
  task bursts(input integer k);
    integer c;
    begin
      c = 0;
      // a sample already in flight still carries the old level
      @(posedge clk_i);
      while (k > 0 && c < 5000) begin
        @(posedge clk_i);
        c = c + 1;
        if (sv === 1'b1) k = k - 1;
      end
      if (k > 0) check("burst_to", 32'h0, k);
      repeat (3) @(posedge clk_i);
    end
  endtask
  task pwr(input [3:0] s);
    begin
      reset_n_i <= 1'b0;
      {sa, sb, ga, gb} <= s;
      lvl <= 16'h1000;
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      bursts(1);
    end
  endtask
  task t_regs;
    reg [31:0] q;
    reg [1:0] r;
    begin
      rchk("ctrl_rst", 8'h00, 32'hFF, {24'h0, `TDP_DRIFT_BASE_RST});
      bus(1'b1, 8'h00, 32'h1, q, r);
      check("wr_ok", `TDP_RESP_OKAY, r);
      bus(1'b1, 8'h00, 32'h0, q, r); // zero pace refused
      wst <= 4'hE;
      bus(1'b1, 8'h00, 32'h22, q, r); // low byte not enabled
      wst <= 4'hF;
      rchk("ctrl_kp", 8'h00, 32'hFF, 32'h1);
      // one lsb down per burst, eight bursts per lsb up
      lvl <= 16'h0FF0;
      bursts(2);
      rchk("ref_dn", 8'h08, 32'hFFFF, 32'h0FFE);
      lvl <= 16'h1010;
      bursts(2);
      rchk("ref_up", 8'h08, 32'hFFFF, 32'h0FFE);
      rchk("sig", 8'h0C, 32'hFFFF, 32'h1010);
      bus(1'b1, 8'h04, 32'h1, q, r);
      check("wr_ro", `TDP_RESP_SLVERR, r);
      bus(1'b0, 8'hFC, 32'h0, q, r);
      check("unmap_r", `TDP_RESP_SLVERR, r);
      check("unmap_d", 32'h0, q);
    end
  endtask
  task t_gain;
    integer i;
    integer sh;
    reg [15:0] t;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        pwr({2'b11, i == 1, i == 2});
        sh = (i == 0) ? `TDP_SHIFT_HIGH : (i == 1) ? `TDP_SHIFT_MED : `TDP_SHIFT_LOW;
        t = 16'h1000 + (16'h1000 >> sh);
        rchk("ref", 8'h08, 32'hFFFF, 32'h1000);
        rchk("thr", 8'h10, 32'hFFFFFFFF, {16'h1000 + ((t - 16'h1000) >> 1), t});
        rchk("gain", 8'h04, 32'hC00, i << 10);
      end
    end
  endtask
  task t_modes;
    integer i;
    reg [2:0] e;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        pwr({i[1:0], 2'b00});
        e = (i == 0) ? 3'h2 : (i == 1) ? 3'h4 : (i == 2) ? 3'h1 : 3'h0;
        rchk("mode", 8'h04, 32'h380, {e, 7'h00});
      end
      sa <= 1'b0;
      sb <= 1'b0;
      repeat (20) @(posedge clk_i);
      rchk("strap_lk", 8'h04, 32'h380, 32'h0);
    end
  endtask
  task t_integ;
    begin
      lvl <= 16'h10C0;
      bursts(3);
      check("integ3", 32'h1, out_n);
      rchk("integ", 8'h04, 32'h70, 32'h30);
      lvl <= 16'h1000;
      bursts(1);
      rchk("integ0", 8'h04, 32'h70, 32'h0);
      lvl <= 16'h10C0;
      bursts(4);
      check("dc_on", 32'h0, out_n);
      lvl <= 16'h1060;
      bursts(2);
      check("hyst_on", 32'h0, out_n);
      rchk("ref_frz", 8'h08, 32'hFFFF, 32'h1000);
      lvl <= 16'h1030;
      bursts(1);
      check("hyst_off", 32'h1, out_n);
    end
  endtask
  task t_to;
    integer i;
    integer ms;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        ms = i ? 80 : 40;
        pwr({1'b1, !i, 2'b00});
        lvl <= 16'h10C0;
        bursts(4);
        repeat ((ms - 3) * TK) @(posedge clk_i);
        check("to_hold", 32'h0, out_n);
        repeat (5 * TK) @(posedge clk_i);
        check("to_end", 32'h1, out_n);
        bursts(2);
        check("to_idle", 32'h1, out_n);
        rchk("recal", 8'h08, 32'hFFFF, 32'h10C0);
      end
    end
  endtask
  task t_toggle;
    begin
      pwr(4'b0000);
      lvl <= 16'h10C0;
      bursts(4);
      check("tg_on", 32'h0, out_n);
      repeat (60 * TK) @(posedge clk_i);
      check("tg_keep", 32'h0, out_n);
      rchk("tg_recal", 8'h08, 32'hFFFF, 32'h10C0);
      lvl <= 16'h1000;
      bursts(1);
      lvl <= 16'h1200;
      bursts(4);
      check("tg_off", 32'h1, out_n);
    end
  endtask
  task t_pulse;
    begin
      pwr(4'b0100);
      lvl <= 16'h10C0;
      bursts(4);
      check("pl_on", 32'h0, out_n);
      repeat ((PM + 2) * TK) @(posedge clk_i);
      check("pl_off", 32'h1, out_n);
    end
  endtask
  initial begin
    pwr(4'b1100);
    t_regs;
    t_gain;
    t_modes;
    t_integ;
    t_to;
    t_toggle;
    t_pulse;
    stop_test;
  end
  // hang guard: the whole sequence needs well under this
  initial begin
    #300000;
    num_errors = num_errors + 1;
    stop_test;
  end
endmodule

/* File: tdp_chk_assertions.sv */
`timescale 1ns/1ps
// port-level checks of the touch detect core
module tdp_chk #(
  parameter TICK_CYCLES = 10,
  parameter BURST_MS = 8,
  parameter CONFIRM_MS = 3,
  parameter PULSE_MS = 5,
  parameter TO_SHORT_MS = 40,
  parameter TO_LONG_MS = 80
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire mode_strap_a_i,
  input wire mode_strap_b_i,
  input wire burst_req_o,
  input wire sample_valid_i,
  input wire out_n_o,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp
);
  localparam int T = TICK_CYCLES;
  reg [31:0] gap_q; // cycles since last burst
  reg [31:0] low_q; // cycles output has been low
  reg seen_q; // a first burst has passed
  reg [1:0] mode_q; // straps as held under reset
  // straps taken under reset only; the core's power-up lock takes them after release
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      gap_q <= 32'h0;
      low_q <= 32'h0;
      seen_q <= 1'b0;
      mode_q <= {mode_strap_a_i, mode_strap_b_i};
    end else begin
      gap_q <= burst_req_o ? 32'h1 : gap_q + 32'h1;
      low_q <= out_n_o ? 32'h0 : low_q + 32'h1;
      seen_q <= seen_q | burst_req_o;
    end
  end
  // one tick of slack: tick phase is not tied to bursts
  wire gap_ok = gap_q >= (CONFIRM_MS - 1) * T && gap_q <= (BURST_MS + 1) * T;
  wire pul_ok = low_q >= (PULSE_MS - 1) * T && low_q <= (PULSE_MS + 1) * T;
  wire to_ok = low_q <= ((mode_q == 2'b10) ? TO_LONG_MS : TO_SHORT_MS) * T + 2 * T;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_RST_IDLE: assert property ($rose(reset_n_i) |-> out_n_o && !burst_req_o)
    else $error("outputs not idle after reset");
  AST_BURST_ONE: assert property (burst_req_o |=> !burst_req_o)
    else $error("burst request too long");
  AST_BURST_GAP: assert property (burst_req_o && seen_q |-> gap_ok)
    else $error("burst spacing out of range");
  // dc follows active one cycle sooner than the toggle and pulse stages
  AST_OUT_CAUSE: assert property ($fell(out_n_o) |->
    (mode_q[1] ? $past(sample_valid_i, 2) : $past(sample_valid_i, 3)))
    else $error("output set without a burst");
  AST_PULSE_LEN: assert property ($rose(out_n_o) && mode_q == 2'b01 |-> pul_ok)
    else $error("pulse width wrong");
  AST_DC_TIMEOUT: assert property (mode_q[1] && !out_n_o |-> to_ok)
    else $error("dc output held past timeout");
  AST_DC_HOLD: assert property ($fell(out_n_o) && mode_q[1] |=> !out_n_o [*3])
    else $error("dc output dropped too soon");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  COV_PULSE: cover property ($rose(out_n_o) && mode_q == 2'b01);
  COV_DC_ON: cover property ($fell(out_n_o) && mode_q[1]);
  COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind tdp_top tdp_chk #(.TICK_CYCLES(TICK_CYCLES), .BURST_MS(BURST_MS),
  .CONFIRM_MS(CONFIRM_MS), .PULSE_MS(PULSE_MS), .TO_SHORT_MS(TO_SHORT_MS),
  .TO_LONG_MS(TO_LONG_MS)) u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .mode_strap_a_i(mode_strap_a_i), .mode_strap_b_i(mode_strap_b_i),
  .burst_req_o(burst_req_o), .sample_valid_i(sample_valid_i), .out_n_o(out_n_o),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));

/* File: tdp_consts.vh */
`ifndef TDP_CONSTS_VH
`define TDP_CONSTS_VH
// timing base
`define TDP_CLK_PERIOD_NS 5
`define TDP_TICK_NS 1000000
`define TDP_BURST_MS 75
`define TDP_CONFIRM_MS 20
`define TDP_PULSE_MS 75
`define TDP_TO_SHORT_MS 10000
`define TDP_TO_LONG_MS 60000
// detection integrator and strap settle
`define TDP_INTEG_LAST 3'h3
`define TDP_STRAP_SETTLE 3'h6
// threshold differential shifts per gain
`define TDP_SHIFT_HIGH 5
`define TDP_SHIFT_MED 4
`define TDP_SHIFT_LOW 3
// up period is down period shifted left by this
`define TDP_DRIFT_RATIO 3
`define TDP_DRIFT_BASE_RST 8'h04
// gain codes
`define TDP_GAIN_HIGH 2'h0
`define TDP_GAIN_MED 2'h1
`define TDP_GAIN_LOW 2'h2
// output modes
`define TDP_MODE_DC 2'h0
`define TDP_MODE_TOGGLE 2'h1
`define TDP_MODE_PULSE 2'h2
// register byte offsets
`define TDP_REG_CTRL 8'h00
`define TDP_REG_STATUS 8'h04
`define TDP_REG_REF 8'h08
`define TDP_REG_SIG 8'h0C
`define TDP_REG_THR 8'h10
// axi responses
`define TDP_RESP_OKAY 2'h0
`define TDP_RESP_SLVERR 2'h2
`endif

/* File: tdp_fe_model.sv */
`timescale 1ns/1ps
// acquisition front end: answers each burst request two cycles later
module tdp_fe_model (
  input wire clk_i,
  input wire burst_req_i,
  input wire [15:0] level_i,
  output reg sample_valid_o,
  output reg [15:0] sample_o
);
  reg req_q; // request seen one cycle ago
  initial begin
    req_q = 1'b0;
    sample_valid_o = 1'b0;
    sample_o = 16'h0000;
  end
  // data only means something with its strobe; otherwise it churns
  always @(posedge clk_i) begin
    req_q <= burst_req_i;
    sample_valid_o <= req_q;
    sample_o <= req_q ? level_i : ~sample_o;
  end
endmodule

/* File: tdp_sync3.v */
`timescale 1ns/1ps
// three-stage synchroniser; output moves once stages two and three agree
module tdp_sync3 (
  input wire clk_i,
  input wire reset_n_i,
  input wire async_i,
  output reg sync_o
);
  reg s1_q; // metastability catcher, read by s2 only
  reg s2_q;
  reg s3_q;

  // shift chain plus agreement filter
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sync_o <= s3_q;
      end
    end
  end
endmodule

/* File: tdp_tick.v */
`timescale 1ns/1ps
// divider giving one-cycle enable every DIV clocks
module tdp_tick #(
  parameter DIV = 200000
) (
  input wire clk_i,
  input wire reset_n_i,
  output reg tick_o
);
  reg [31:0] cnt_q; // cycles since last tick

  // free-running count, pulse at wrap
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_q <= 32'h00000000;
      tick_o <= 1'b0;
    end else if (cnt_q == DIV - 1) begin
      cnt_q <= 32'h00000000;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h00000001;
      tick_o <= 1'b0;
    end
  end
endmodule

/* File: tdp_top.v */
`timescale 1ns/1ps
`include "tdp_consts.vh"
// touch detect processing core with axi4-lite status/config access
module tdp_top #(
  parameter SIG_W = 16,
  parameter TICK_CYCLES = `TDP_TICK_NS / `TDP_CLK_PERIOD_NS,
  parameter BURST_MS = `TDP_BURST_MS,
  parameter CONFIRM_MS = `TDP_CONFIRM_MS,
  parameter PULSE_MS = `TDP_PULSE_MS,
  parameter TO_SHORT_MS = `TDP_TO_SHORT_MS,
  parameter TO_LONG_MS = `TDP_TO_LONG_MS
) (
  input wire clk_i,
  input wire reset_n_i,
  // straps from pins
  input wire mode_strap_a_i,
  input wire mode_strap_b_i,
  input wire gain_on_sense_line_a_i,
  input wire gain_on_sense_line_b_i,
  // acquisition front end, same clock
  output wire burst_req_o,
  input wire sample_valid_i,
  input wire [SIG_W-1:0] sample_i,
  // detection output, active low
  output wire out_n_o,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);
  localparam [15:0] BURST_L = BURST_MS;
  localparam [15:0] CONFIRM_L = CONFIRM_MS;
  localparam [15:0] PULSE_L = PULSE_MS;
  localparam [15:0] TO_SHORT_L = TO_SHORT_MS;
  localparam [15:0] TO_LONG_L = TO_LONG_MS;

  // synchronised strap levels
  wire mode_a_s;
  wire mode_b_s;
  wire gain_a_s;
  wire gain_b_s;
  wire tick_ms; // 1 ms enable

  tdp_sync3 u_sync_ma (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .async_i(mode_strap_a_i), .sync_o(mode_a_s));
  tdp_sync3 u_sync_mb (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .async_i(mode_strap_b_i), .sync_o(mode_b_s));
  tdp_sync3 u_sync_ga (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .async_i(gain_on_sense_line_a_i), .sync_o(gain_a_s));
  tdp_sync3 u_sync_gb (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .async_i(gain_on_sense_line_b_i), .sync_o(gain_b_s));
  tdp_tick #(.DIV(TICK_CYCLES)) u_tick (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .tick_o(tick_ms));

  // strap capture state
  reg [2:0] settle_q; // cycles since reset release
  reg run_q; // straps latched, processing enabled
  reg [1:0] mode_q; // output mode
  reg to_long_q; // 60 s timeout selected
  reg [1:0] gain_q; // sensitivity code

  // straps are caught once after release and never again
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      settle_q <= 3'h0;
      run_q <= 1'b0;
      mode_q <= `TDP_MODE_DC;
      to_long_q <= 1'b0;
      gain_q <= `TDP_GAIN_HIGH;
    end else if (!run_q) begin
      if (settle_q == `TDP_STRAP_SETTLE) begin
        run_q <= 1'b1;
        // decode a/b: hh dc10, hl dc60, ll toggle, lh pulse
        case ({mode_a_s, mode_b_s})
          2'h3: mode_q <= `TDP_MODE_DC;
          2'h2: begin
            mode_q <= `TDP_MODE_DC;
            to_long_q <= 1'b1;
          end
          2'h0: mode_q <= `TDP_MODE_TOGGLE;
          default: mode_q <= `TDP_MODE_PULSE;
        endcase
        // open strap gives highest sensitivity
        if (gain_a_s) begin
          gain_q <= `TDP_GAIN_MED;
        end else if (gain_b_s) begin
          gain_q <= `TDP_GAIN_LOW;
        end else begin
          gain_q <= `TDP_GAIN_HIGH;
        end
      end else begin
        settle_q <= settle_q + 3'h1;
      end
    end
  end

  // software-set drift pace, in bursts per down step
  reg [7:0] drift_base_q;
  wire [10:0] up_per = {drift_base_q, 3'h0};
  wire [10:0] dn_per = {3'h0, drift_base_q};

  // signal path state
  reg [SIG_W-1:0] ref_q; // reference level
  reg [SIG_W-1:0] sig_q; // last raw sample
  reg cal_q; // next sample loads reference
  reg active_q; // confirmed detection in effect
  reg [2:0] integ_q; // detection integrator
  reg [10:0] up_cnt_q; // bursts above reference
  reg [10:0] dn_cnt_q; // bursts below reference
  reg [15:0] on_ms_q; // detection duration
  reg newdet_q; // pulse: fresh confirmed detection
  reg timeout_q; // pulse: max on-duration expired
  reg [SIG_W-1:0] diff; // threshold differential

  // differential is a fraction of the reference itself
  always @* begin
    case (gain_q)
      `TDP_GAIN_MED: diff = ref_q >> `TDP_SHIFT_MED;
      `TDP_GAIN_LOW: diff = ref_q >> `TDP_SHIFT_LOW;
      default: diff = ref_q >> `TDP_SHIFT_HIGH;
    endcase
  end

  // combinational so both levels move with every reference step
  wire [SIG_W:0] thr = {1'b0, ref_q} + {1'b0, diff};
  wire [SIG_W:0] hyst = {1'b0, ref_q} + {2'b0, diff[SIG_W-1:1]};
  wire [SIG_W:0] smp = {1'b0, sample_i};
  wire above = smp > thr;
  wire hold = smp >= hyst;
  wire [15:0] to_lim = (to_long_q && mode_q == `TDP_MODE_DC) ? TO_LONG_L : TO_SHORT_L;

  // acquisition processing, drift, integrator and timeout
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ref_q <= {SIG_W{1'b0}};
      sig_q <= {SIG_W{1'b0}};
      cal_q <= 1'b1;
      active_q <= 1'b0;
      integ_q <= 3'h0;
      up_cnt_q <= 11'h000;
      dn_cnt_q <= 11'h000;
      on_ms_q <= 16'h0000;
      newdet_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      newdet_q <= 1'b0;
      timeout_q <= 1'b0;
      if (run_q && sample_valid_i) begin
        sig_q <= sample_i;
        if (cal_q) begin
          // calibration: reference snaps to the signal
          ref_q <= sample_i;
          cal_q <= 1'b0;
          integ_q <= 3'h0;
          up_cnt_q <= 11'h000;
          dn_cnt_q <= 11'h000;
        end else if (active_q) begin
          // reference frozen; only the dropout check runs
          if (!hold) begin
            active_q <= 1'b0;
          end
        end else if (above) begin
          if (integ_q == `TDP_INTEG_LAST) begin
            active_q <= 1'b1;
            newdet_q <= 1'b1;
            integ_q <= 3'h0;
          end else begin
            integ_q <= integ_q + 3'h1;
          end
        end else begin
          integ_q <= 3'h0;
          // slow slew-limited tracking, one lsb per period
          if (sample_i > ref_q) begin
            dn_cnt_q <= 11'h000;
            if (up_cnt_q + 11'h001 >= up_per) begin
              ref_q <= ref_q + {{(SIG_W-1){1'b0}}, 1'b1};
              up_cnt_q <= 11'h000;
            end else begin
              up_cnt_q <= up_cnt_q + 11'h001;
            end
          end else if (sample_i < ref_q) begin
            up_cnt_q <= 11'h000;
            // shorter period: falling signals recover fast
            if (dn_cnt_q + 11'h001 >= dn_per) begin
              ref_q <= ref_q - {{(SIG_W-1){1'b0}}, 1'b1};
              dn_cnt_q <= 11'h000;
            end else begin
              dn_cnt_q <= dn_cnt_q + 11'h001;
            end
          end else begin
            up_cnt_q <= 11'h000;
            dn_cnt_q <= 11'h000;
          end
        end
      end
      // max on-duration timer, cleared whenever not detecting
      if (!active_q) begin
        on_ms_q <= 16'h0000;
      end else if (tick_ms) begin
        if (on_ms_q + 16'h0001 >= to_lim) begin
          // stuck: drop detection and recalibrate on next burst
          active_q <= 1'b0;
          cal_q <= 1'b1;
          integ_q <= 3'h0;
          timeout_q <= 1'b1;
          on_ms_q <= 16'h0000;
        end else begin
          on_ms_q <= on_ms_q + 16'h0001;
        end
      end
    end
  end

  // burst scheduler
  reg [15:0] gap_q; // ms since last burst
  reg burst_q; // one-cycle burst request
  wire [15:0] gap_lim = (integ_q != 3'h0) ? CONFIRM_L : BURST_L;

  // confirming bursts come sooner so reaction stays short
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      gap_q <= 16'h0000;
      burst_q <= 1'b0;
    end else begin
      burst_q <= 1'b0;
      if (run_q && tick_ms) begin
        if (gap_q + 16'h0001 >= gap_lim) begin
          gap_q <= 16'h0000;
          burst_q <= 1'b1;
        end else begin
          gap_q <= gap_q + 16'h0001;
        end
      end
    end
  end
  assign burst_req_o = burst_q;

  // output stage
  reg out_n_q; // registered pin level
  reg toggle_q; // toggle mode state, 1 = active
  reg [15:0] pulse_q; // pulse ms remaining

  // mode-dependent output
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      out_n_q <= 1'b1;
      toggle_q <= 1'b0;
      pulse_q <= 16'h0000;
    end else begin
      if (newdet_q) begin
        toggle_q <= ~toggle_q;
      end
      if (newdet_q) begin
        pulse_q <= PULSE_L;
      end else if (tick_ms && pulse_q != 16'h0000) begin
        pulse_q <= pulse_q - 16'h0001;
      end
      case (mode_q)
        // timeout clears active_q, so output goes inactive
        `TDP_MODE_DC: out_n_q <= ~active_q;
        // timeout leaves toggle_q untouched
        `TDP_MODE_TOGGLE: out_n_q <= ~toggle_q;
        `TDP_MODE_PULSE: out_n_q <= (pulse_q == 16'h0000);
        default: out_n_q <= 1'b1;
      endcase
    end
  end
  assign out_n_o = out_n_q;

  // axi4-lite write channel
  reg aw_full_q; // address captured
  reg w_full_q; // data captured
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // address and data taken in any order, write once both held
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `TDP_RESP_OKAY;
      drift_base_q <= `TDP_DRIFT_BASE_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_full_q && w_full_q) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        if (aw_addr_q == `TDP_REG_CTRL) begin
          bresp_q <= `TDP_RESP_OKAY;
          // zero would step the reference every burst both ways; keep the old pace instead
          if (w_strb_q[0] && w_data_q[7:0] != 8'h00) begin
            drift_base_q <= w_data_q[7:0];
          end
        end else begin
          // read-only or unmapped
          bresp_q <= `TDP_RESP_SLVERR;
        end
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg [31:0] rd_mux;
  reg rd_ok;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // read decode, unused upper bits zero
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `TDP_REG_CTRL: rd_mux = {24'h000000, drift_base_q};
      `TDP_REG_STATUS: rd_mux = {20'h00000, gain_q, mode_q, to_long_q,
        integ_q, cal_q, ~out_n_q, active_q, run_q};
      `TDP_REG_REF: rd_mux = {{(32-SIG_W){1'b0}}, ref_q};
      `TDP_REG_SIG: rd_mux = {{(32-SIG_W){1'b0}}, sig_q};
      `TDP_REG_THR: rd_mux = {hyst[SIG_W-1:0], thr[SIG_W-1:0]};
      default: begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // one read outstanding; data registered a cycle after address
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `TDP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? `TDP_RESP_OKAY : `TDP_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule
